// [pkg/xsp_defines.vh]
// xsp_defines.vh: constants for the transceiver status-pin and host-port select block
// assumes inclusion by bare name from core files
`ifndef XSP_DEFINES_VH
`define XSP_DEFINES_VH
`define XSP_STAT_LIVE_LOL_BIT  4
`define XSP_STAT_LATCH_LOL_BIT 4
`define XSP_SRC_LOL            0
`define XSP_SRC_LOS            1
`define XSP_SRC_FIFO           2
`define XSP_NSRC               3
`define XSP_CMU_MULT           7'h40
`define XSP_CLK622_HALF        8'h01
`define XSP_DRV_OPEN_DRAIN     1'b0
`define XSP_DRV_PUSH_PULL      1'b1
`define XSP_SYNC_IDLE          12'h00C
`define XSP_STATUS_RST         8'h00
`define XSP_PORT_SEL_RST       1'b1
`endif

// [core/xsp_status_pins.v]
// xsp_status_pins.v: status pins, interrupt, host-port select for the optical transceiver
// assumes analog detectors, cdr and serial protocol engine sit outside; flags are pins
// assumes mask, enable, clear and drive controls come from register logic on i_clock
//
// Behaviour
// - interrupt output is active low, pulled low on pending unmasked events
// - each source has a mask; pending sources readable as status vector
// - global enable cleared means interrupt output never asserts
// - interrupt driver open drain or push pull, open drain after reset
// - lock-lost output high during loss of lock; unmasked it interrupts
// - live lock-lost at status bit 4, latched copy at latched bit 4
// - without reference clock, lock loss judged from data quality measure
// - lock-lost pin may instead carry the 622 MHz tx clock sampled on i_clock, an aliased copy
// - signal-lost output high when any analog, count or quality detector reports loss
// - multiplier mode with synchronous reference gives line rate of 64 times reference
// - tx path fifo absorbs jitter between recovered data and multiplied clock
// - reference clock optional, feeds multiplier and both clock recoveries
// - port select low picks i2c, high picks spi-like, default high
// - host serial data pin open drain default or push pull, starts high-z
`timescale 1ns/1ps
`default_nettype none
`include "xsp_defines.vh"
module xsp_status_pins #(
  parameter NSRC = `XSP_NSRC
) (
  input  wire            i_clock,
  input  wire            i_resetn,
  input  wire            i_ref_present,        // reference clock detected
  input  wire            i_ref_lock_lost,      // reference-comparison lock detector
  input  wire            i_quality_lock_lost,  // data-quality lock detector
  input  wire            i_los_analog,
  input  wire            i_los_count,
  input  wire            i_los_quality,
  input  wire            i_tx_fifo_err,        // tx jitter fifo over/underflow
  input  wire            i_tx_clk622,          // 622 MHz clock derived from tx input
  input  wire            i_lol_clock_mode,     // lock-lost pin carries clock
  input  wire [NSRC-1:0] i_irq_mask,           // 1 = source enabled
  input  wire            i_irq_global_en,
  input  wire            i_irq_push_pull,
  input  wire            i_sd_push_pull,
  input  wire [NSRC-1:0] i_latch_clear,        // write-one-to-clear pulses
  input  wire            i_host_port_select,
  input  wire            i_host_cs_n,
  input  wire            i_host_sck,
  input  wire            i_sd_drive_low,       // serial engine wants data pin low
  input  wire            i_sd_drive_en,        // serial engine owns data pin
  output wire            o_irq_n_out,
  output wire            o_irq_n_oe,
  output reg             o_rx_lock_lost_out,
  output reg             o_rx_signal_lost_out,
  output reg  [7:0]      o_live_status,
  output reg  [7:0]      o_latched_status,
  output reg  [NSRC-1:0] o_irq_pending,
  output reg             o_spi_mode,
  output reg             o_spi_selected,
  output reg             o_sck_rise,
  output reg             o_sck_fall,
  output wire            o_sd_out,
  output wire            o_sd_oe,
  output wire [6:0]      o_cmu_multiplier,
  output wire            o_cdr_use_reference
);
  // reset release through two flops
  // asynchronous assert, synchronous release so no flop leaves reset on a skewed edge
  reg rst_s1_ff, rst_s2_ff;
  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= rst_s1_ff;
    end
  end
  wire rst_n = rst_s2_ff;

  // every outside level except the register controls and the serial engine drive requests crosses two flops; first stage read only by second
  // trade-off: two flops add latency but keep metastability off the flags
  localparam NIN = 12;
  wire [NIN-1:0] raw_in = {i_ref_present, i_ref_lock_lost, i_quality_lock_lost, i_los_analog, i_los_count,
                           i_los_quality, i_tx_fifo_err, i_tx_clk622, i_host_port_select, i_host_cs_n,
                           i_host_sck, i_lol_clock_mode};
  reg [NIN-1:0] sync1_ff, sync2_ff;
  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      sync1_ff <= `XSP_SYNC_IDLE; // select and chip select idle high like the pull-ups
      sync2_ff <= `XSP_SYNC_IDLE;
    end else begin
      sync1_ff <= raw_in;
      sync2_ff <= sync1_ff;
    end
  end
  wire ref_present  = sync2_ff[11];
  wire ref_lol      = sync2_ff[10];
  wire qual_lol     = sync2_ff[9];
  wire los_a        = sync2_ff[8];
  wire los_c        = sync2_ff[7];
  wire los_q        = sync2_ff[6];
  wire fifo_err     = sync2_ff[5];
  wire clk622       = sync2_ff[4];
  wire port_sel     = sync2_ff[3];
  wire cs_n         = sync2_ff[2];
  wire sck          = sync2_ff[1];
  wire lol_clk_mode = sync2_ff[0];

  // lock detector choice: reference compare when present, else data quality
  wire lol_live = ref_present ? ref_lol : qual_lol;
  wire los_live = los_a | los_c | los_q;
  // clock-plan hints for the analog side
  assign o_cmu_multiplier    = `XSP_CMU_MULT;
  assign o_cdr_use_reference = ref_present;

  // sources and latching; set beats clear so no edge is lost
  wire [NSRC-1:0] src = {fifo_err, los_live, lol_live}; // fifo flag
  reg  [NSRC-1:0] nxt_pend;
  reg             nxt_lol_pin;
  reg             sck_d_ff;

  // pending: a clear pulse only wins once its source has gone quiet
  always @* begin
    nxt_pend = (o_irq_pending & ~i_latch_clear) | src;
  end

  // lock-lost pin: level by default, or the sampled 622 MHz copy
  // a clock this fast is only sampled here; the pin shows the aliased copy
  always @* begin
    nxt_lol_pin = lol_live;
    if (lol_clk_mode) begin
      nxt_lol_pin = clk622;
    end
  end

  // sticky pending vector, readable as interrupt status
  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_irq_pending <= {NSRC{1'b0}};
    end else begin
      o_irq_pending <= nxt_pend;
    end
  end

  // status pins one flop after the synchronisers, so 3 clocks pin to pin
  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_rx_lock_lost_out   <= 1'b0;
      o_rx_signal_lost_out <= 1'b0;
    end else begin
      o_rx_lock_lost_out   <= nxt_lol_pin;
      o_rx_signal_lost_out <= los_live;
    end
  end

  // live status byte: only the lock bit is defined in this block
  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_live_status <= `XSP_STATUS_RST;
    end else begin
      o_live_status <= `XSP_STATUS_RST;
      o_live_status[`XSP_STAT_LIVE_LOL_BIT] <= lol_live;
    end
  end

  // latched byte mirrors the next pending lock bit, so it never lags the flag
  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_latched_status <= `XSP_STATUS_RST;
    end else begin
      o_latched_status <= `XSP_STATUS_RST;
      o_latched_status[`XSP_STAT_LATCH_LOL_BIT] <= nxt_pend[`XSP_SRC_LOL];
    end
  end

  // port select and chip select; reset values match the pull-ups
  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_spi_mode     <= `XSP_PORT_SEL_RST;
      o_spi_selected <= 1'b0;
    end else begin
      o_spi_mode     <= port_sel;
      o_spi_selected <= port_sel & ~cs_n;
    end
  end

  // serial clock edges; the delay flop idles low like an idle link clock
  // limitation: edges closer than one system clock apart are merged
  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      sck_d_ff   <= 1'b0;
      o_sck_rise <= 1'b0;
      o_sck_fall <= 1'b0;
    end else begin
      sck_d_ff   <= sck;
      o_sck_rise <= sck & ~sck_d_ff;
      o_sck_fall <= ~sck & sck_d_ff;
    end
  end

  // interrupt pin: global enable gates all, driver type chosen by software
  // registered so the pin never glitches while pending bits settle
  reg irq_act_ff;
  reg nxt_irq_act;
  always @* begin
    nxt_irq_act = i_irq_global_en & |(o_irq_pending & i_irq_mask);
  end

  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_act_ff <= 1'b0;
    end else begin
      irq_act_ff <= nxt_irq_act;
    end
  end

  // open drain drives only the low level; push pull drives both levels
  assign o_irq_n_out = ~irq_act_ff;
  assign o_irq_n_oe  = irq_act_ff | (i_irq_push_pull == `XSP_DRV_PUSH_PULL);

  // data pin: open drain drives only low; push pull drives when engine owns it
  // push pull starts released: oe waits until the serial engine owns the pin
  assign o_sd_out = ~i_sd_drive_low;
  assign o_sd_oe  = rst_n & i_sd_drive_en &
                    ((i_sd_push_pull == `XSP_DRV_PUSH_PULL) | i_sd_drive_low);
endmodule // xsp_status_pins
`default_nettype wire

// [dv/xsp_status_pins_checker.sv]
// checker for the status-pin block, bound to its top ports
// assumes one clock domain, raw async active-low reset
`timescale 1ns/1ps
`default_nettype none
module xsp_status_pins_checker #(parameter NSRC = 3) (
  input wire logic            i_clock, i_resetn, i_irq_global_en, i_irq_push_pull, i_sd_push_pull,
  input wire logic            i_los_analog, i_los_count, i_los_quality, i_host_port_select, i_sd_drive_en,
  input wire logic [NSRC-1:0] i_irq_mask, i_latch_clear, o_irq_pending,
  input wire logic            o_irq_n_out, o_irq_n_oe, o_rx_signal_lost_out, o_spi_mode, o_spi_selected,
  input wire logic            o_sd_out, o_sd_oe,
  input wire logic [7:0]      o_live_status, o_latched_status,
  input wire logic [6:0]      o_cmu_multiplier
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  // 8 samples covers internal reset release plus 3-cycle pin path
  sequence los_on; (i_los_analog || i_los_count || i_los_quality) [*8]; endsequence
  sequence los_off; !(i_los_analog || i_los_count || i_los_quality) [*8]; endsequence
  a_irq_gate_off: assert property (!$past(i_irq_global_en) |-> o_irq_n_out) else $error("irq with enable off");
  a_irq_fire_on: assert property (i_irq_global_en && |(o_irq_pending & i_irq_mask) |=> !o_irq_n_out && o_irq_n_oe)
    else $error("irq not driven low");
  a_irq_od_high: assert property (!i_irq_push_pull && o_irq_n_oe |-> !o_irq_n_out) else $error("od drove high");
  a_lol_latched: assert property (o_live_status[4] |-> o_latched_status[4]) else $error("latch missed");
  a_latch_hold: assert property ($fell(o_latched_status[4]) |-> $past(i_latch_clear[0])) else $error("latch lost");
  a_los_set: assert property (los_on |-> o_rx_signal_lost_out) else $error("los not set");
  a_los_clear: assert property (los_off |-> !o_rx_signal_lost_out) else $error("los stuck");
  a_spi_pick: assert property (i_host_port_select [*8] |-> o_spi_mode) else $error("spi not picked");
  a_i2c_pick: assert property (!i_host_port_select [*8] |-> !o_spi_mode && !o_spi_selected)
    else $error("i2c not picked");
  a_sd_drive: assert property (o_sd_oe |-> i_sd_drive_en && (i_sd_push_pull || !o_sd_out)) else $error("sd drive bad");
  a_cmu_mult: assert property (o_cmu_multiplier == 7'h40) else $error("multiplier wrong");
endmodule // xsp_status_pins_checker
bind xsp_status_pins xsp_status_pins_checker #(.NSRC(NSRC)) chk_u (.*);
`default_nettype wire

// [dv/xsp_host_model.sv]
// module microcontroller: serial clock and chip select for one frame
// assumes a rising i_go starts a frame; clock stands low between frames
`timescale 1ns/1ps
`default_nettype none
module xsp_host_model (
  input  wire logic i_go,
  output logic      o_sck,
  output logic      o_cs_n
);
  initial begin o_sck = 1'b0; o_cs_n = 1'b1; end // chip select idles high as if pulled up, clock idles low
  // 125 ns link clock only inside a frame
  always @(posedge i_go) begin
    o_cs_n = 1'b0;
    repeat (8) begin #62.5 o_sck = 1'b1; #62.5 o_sck = 1'b0; end
    o_cs_n = 1'b1;
  end
endmodule // xsp_host_model
`default_nettype wire

// [dv/tb.sv]
// self-checking bench for the status-pin block
// assumes inputs driven on falling edges, 5 ns clock
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 0, rstn = 0, rp = 0, rl = 0, ql = 0, la = 0, lc = 0, lq = 0, en = 0, ipp = 0, spp = 0, sel = 1;
  logic dl = 0, de = 0, go = 0, fe = 0, lcm = 0, c6 = 0;
  wire sckr, sckf, cdr;
  wire [2:0] pnd;
  int n_rise = 0, n_fall = 0;
  logic [2:0] mk = 0, clr = 0;
  wire sck, csn, irqn, irqoe, lol, los, spim, spis, sdo, sdoe;
  wire [7:0] lt;
  int n_fail = 0, compares = 0;
  // rows: {ref, ref lol, quality lol, los a/c/q, enable, mask} then {lol, los, irq_n}
  logic [10:0] rows [6] = '{11'h61C, 11'h519, 11'h11C, 11'h093, 11'h04B, 11'h03A};
  always #2.5 clk = ~clk;
  always @(posedge clk) begin n_rise <= n_rise + sckr; n_fall <= n_fall + sckf; end
  xsp_host_model host_u (.i_go(go), .o_sck(sck), .o_cs_n(csn));
  xsp_status_pins dut_u (.i_clock(clk), .i_resetn(rstn), .i_ref_present(rp), .i_ref_lock_lost(rl),
    .i_quality_lock_lost(ql), .i_los_analog(la), .i_los_count(lc), .i_los_quality(lq), .i_tx_fifo_err(fe),
    .i_tx_clk622(c6), .i_lol_clock_mode(lcm), .i_irq_mask(mk), .i_irq_global_en(en), .i_irq_push_pull(ipp),
    .i_sd_push_pull(spp), .i_latch_clear(clr), .i_host_port_select(sel), .i_host_cs_n(csn), .i_host_sck(sck),
    .i_sd_drive_low(dl), .i_sd_drive_en(de), .o_irq_n_out(irqn), .o_irq_n_oe(irqoe), .o_rx_lock_lost_out(lol),
    .o_rx_signal_lost_out(los), .o_live_status(), .o_latched_status(lt), .o_irq_pending(pnd), .o_spi_mode(spim),
    .o_spi_selected(spis), .o_sck_rise(sckr), .o_sck_fall(sckf), .o_sd_out(sdo), .o_sd_oe(sdoe),
    .o_cmu_multiplier(), .o_cdr_use_reference(cdr));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin n_fail++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end
  endtask
  task automatic complete_run;
    $display("fails %0d compares %0d", n_fail, compares);
    if (n_fail == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic step(input int n); repeat (n) @(negedge clk); endtask
  // hang guard: far beyond the sequence length
  initial begin #100000; n_fail++; complete_run; end
  initial begin
    step(3);
    chk("reset pins", {irqoe, irqn, spim}, 3'h3);
    rstn = 1;
    step(6);
    foreach (rows[i]) begin
      {rp, rl, ql, la, lc, lq, en} = rows[i][10:4];
      mk = {3{rows[i][3]}};
      step(8);
      chk("row pins", {lol, los, irqn}, rows[i][2:0]);
      chk("row latch", lt[4], rows[i][2]);
      {rp, rl, ql, la, lc, lq} = 6'h00;
      step(5);
      clr = 3'h7;
      step(1);
      clr = 3'h0;
      step(2);
      $display("row %0d done", i);
    end
    // lock loss gone before software clears it
    rp = 1; rl = 1; step(8); rl = 0; step(8);
    chk("sticky", {lt[4], lol}, 3'h2);
    chk("cdr ref", cdr, 8'h1);
    clr = 3'h1; step(1); clr = 3'h0; step(3);
    chk("cleared", lt[4], 3'h0);
    ipp = 1; step(3);
    chk("pp idle", {irqoe, irqn}, 3'h3);
    ipp = 0; de = 1; dl = 1; #1;
    chk("sd od low", {sdoe, sdo}, 3'h2);
    dl = 0; #1;
    chk("sd od off", sdoe, 3'h0);
    de = 0; spp = 1; #1;
    chk("sd pp hiz", sdoe, 3'h0);
    de = 1; #1;
    chk("sd pp high", {sdoe, sdo}, 8'h3);
    de = 0;
    $display("pin drive test done");
    fe = 1; step(8);
    chk("fifo irq", {pnd[2], irqn}, 8'h2);
    fe = 0; step(5); clr = 3'h4; step(1); clr = 3'h0; step(3);
    chk("fifo clr", pnd, 8'h0);
    lcm = 1; rl = 1; step(8);
    chk("lol clk lo", lol, 8'h0);
    c6 = 1; step(8);
    chk("lol clk hi", lol, 8'h1);
    lcm = 0; c6 = 0; rl = 0; step(5); clr = 3'h1; step(1); clr = 3'h0; step(3);
    $display("clock and fifo test done");
    go = 1; step(30);
    chk("spi frame", {spim, spis}, 3'h3);
    step(200);
    chk("sck rises", n_rise[7:0], 8'h8);
    chk("sck falls", n_fall[7:0], 8'h8);
    go = 0; sel = 0; step(8);
    chk("i2c mode", {spim, spis}, 3'h0);
    $display("port select test done");
    complete_run;
  end
endmodule // tb
`default_nettype wire
